// File: hw/ext_irq_channel.sv
// One external interrupt channel: synchroniser, polarity, edge or level pending flag
`timescale 1ns/1ps
module ext_irq_channel (
    // Clock and reset
    input  wire logic sys_clk,
    input  wire logic sys_rst,
    // Selected pin and configuration
    input  wire logic pinIn,
    input  wire logic polarity,
    input  wire logic edgeSel,
    // Core vector acknowledge
    input  wire logic vectorAck,
    // Software write of the pending bit
    input  wire logic swWrite,
    input  wire logic swValue,
    // Pending flag towards the core
    output logic      pending
);

    logic syncFirst_r;
    logic syncSecond_r;
    logic prevActive_r;
    logic active;
    logic edgeSeen;
    logic pending_r;

    // Two flip-flop synchroniser; first stage feeds only the second
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            syncFirst_r  <= 1'b1;         // Idle level of a pulled-up pin
            syncSecond_r <= 1'b1;         // Avoids a false request after reset
        end else begin
            syncFirst_r  <= pinIn;        // RL12
            syncSecond_r <= syncFirst_r;  // RL12
        end
    end

    // Active level under the chosen polarity; 0 means active low
    assign active   = polarity ? syncSecond_r : ~syncSecond_r; // RL1
    assign edgeSeen = active & ~prevActive_r;                  // RL12

    // Previous active state for edge detection
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            prevActive_r <= 1'b0;
        end else begin
            prevActive_r <= active;
        end
    end

    // Pending flag: edge mode latches, level mode follows the input
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pending_r <= 1'b0;
        end else if (!edgeSel) begin
            pending_r <= active;          // RL8 RL10
        end else if (edgeSeen) begin
            pending_r <= 1'b1;            // RL7 set wins over clear
        end else if (vectorAck) begin
            pending_r <= 1'b0;            // RL7
        end else if (swWrite) begin
            pending_r <= swValue;
        end
    end

    assign pending = pending_r;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    property p_sync_delay;
        ##2 (syncSecond_r == $past(pinIn, 2));
    endproperty
    a_sync_delay: assert property (p_sync_delay) else $error("sync delay wrong"); // RL12

    property p_polarity;
        !polarity |-> (active == !syncSecond_r);
    endproperty
    a_polarity: assert property (p_polarity) else $error("active low wrong"); // RL1

    property p_edge_sets;
        (edgeSel && edgeSeen) |=> pending;
    endproperty
    a_edge_sets: assert property (p_edge_sets) else $error("edge lost"); // RL7

    property p_ack_clears;
        (edgeSel && !edgeSeen && vectorAck) |=> !pending;
    endproperty
    a_ack_clears: assert property (p_ack_clears) else $error("ack no clear"); // RL7

    property p_edge_holds;
        (edgeSel && !edgeSeen && !vectorAck && !swWrite) |=> $stable(pending);
    endproperty
    a_edge_holds: assert property (p_edge_holds) else $error("flag drifted"); // RL7

    property p_level_follows;
        !edgeSel |=> (pending == $past(active));
    endproperty
    a_level_follows: assert property (p_level_follows) else $error("level flag"); // RL8

endmodule : ext_irq_channel

// File: hw/ext_irq_pkg.sv
// Package of addresses, field positions and reset values for the external interrupt inputs
package ext_irq_pkg;

    // Special function register addresses
    localparam logic [7:0] TIMER_CTRL_ADDR   = 8'h88;
    localparam logic [7:0] EXT_CFG_ADDR      = 8'he4;
    localparam logic [7:0] EXT_PRIO_ADDR     = 8'hf6;

    // Reset values
    localparam logic [7:0] TIMER_CTRL_RST    = 8'h00;
    localparam logic [7:0] EXT_CFG_RST       = 8'h01;
    localparam logic [7:0] EXT_PRIO_RST      = 8'h00;

    // Timer control register fields owned by this block
    localparam int         ZERO_EDGE_BIT     = 0;
    localparam int         ZERO_PEND_BIT     = 1;
    localparam int         ONE_EDGE_BIT      = 2;
    localparam int         ONE_PEND_BIT      = 3;

    // External interrupt configuration register fields
    localparam int         ZERO_SEL_LSB      = 0;
    localparam int         ZERO_POL_BIT      = 3;
    localparam int         ONE_SEL_LSB       = 4;
    localparam int         ONE_POL_BIT       = 7;
    localparam int         SEL_WIDTH         = 3;

    // Extended priority register field
    localparam int         COUNTER_PRIO_BIT  = 2;

    // Pin synchroniser depth
    localparam int         SYNC_STAGES       = 2;

endpackage : ext_irq_pkg

// File: hw/external_interrupt_inputs.sv
// External interrupt inputs: register port, pin routing and two detection channels
`timescale 1ns/1ps
// Contract
// RL1: Sensitivity bit 1 means edge, 0 level; polarity 0 active low, 1 high.
// RL2: Polarity from configuration register, edge or level from timer control register.
// RL3: Each input taken from the port pin its select field names.
// RL4: Pins are only sampled; their drive and crossbar users stay untouched.
// RL5: Software skips the pin in the crossbar, open-drain with latch one.
// RL6: Pending flags read at timer control bits 1 and 3.
// RL7: Edge mode sets flag on active edge; cleared when core vectors.
// RL8: Level mode flag follows active input level without latching.
// RL9: Source holds a level request until the device recognises it.
// RL10: Level still active after the routine raises a new request.
// RL11: Extended priority bit 2 picks counter array interrupt priority.
// RL12: Pins synchronised; edge is inactive to active between samples.
module external_interrupt_inputs #(
    parameter int PIN_COUNT = 8
) (
    // Clock and reset
    input  wire logic                 sys_clk,
    input  wire logic                 sys_rst,
    // Port pins, sampled only
    input  wire logic [PIN_COUNT-1:0] portPins,
    // Special function register port
    input  wire logic [7:0]           sfrAddr,
    input  wire logic                 sfrWrEn,
    input  wire logic [7:0]           sfrWrData,
    input  wire logic                 sfrRdEn,
    output logic      [7:0]           sfrRdData,
    // Core vector acknowledges
    input  wire logic                 irqZeroAck,
    input  wire logic                 irqOneAck,
    // Requests and priority towards the core
    output logic                      irqZeroPending,
    output logic                      irqOnePending,
    output logic                      counterArrayHighPriority,
    output logic      [7:0]           extPriority
);

    logic [7:0] extCfg_r;
    logic [7:0] extPrio_r;
    logic       zeroEdgeSel_r;
    logic       oneEdgeSel_r;
    logic [7:0] rdData_r;
    logic [7:0] rdData_nxt;
    logic       tconWrite;
    logic [ext_irq_pkg::SEL_WIDTH-1:0] zeroSel;
    logic [ext_irq_pkg::SEL_WIDTH-1:0] oneSel;
    logic       zeroPin;
    logic       onePin;
    logic       zeroPol;
    logic       onePol;

    // Write decode of the timer control register
    assign tconWrite = sfrWrEn && (sfrAddr == ext_irq_pkg::TIMER_CTRL_ADDR);

    // Configuration register: pin selects and polarities
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            extCfg_r <= ext_irq_pkg::EXT_CFG_RST;
        end else if (sfrWrEn && (sfrAddr == ext_irq_pkg::EXT_CFG_ADDR)) begin
            extCfg_r <= sfrWrData; // RL2
        end
    end

    // Extended priority register
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            extPrio_r <= ext_irq_pkg::EXT_PRIO_RST;
        end else if (sfrWrEn && (sfrAddr == ext_irq_pkg::EXT_PRIO_ADDR)) begin
            extPrio_r <= sfrWrData; // RL11
        end
    end

    // Edge or level select bits held in timer control
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            zeroEdgeSel_r <= ext_irq_pkg::TIMER_CTRL_RST[ext_irq_pkg::ZERO_EDGE_BIT];
            oneEdgeSel_r  <= ext_irq_pkg::TIMER_CTRL_RST[ext_irq_pkg::ONE_EDGE_BIT];
        end else if (tconWrite) begin
            zeroEdgeSel_r <= sfrWrData[ext_irq_pkg::ZERO_EDGE_BIT]; // RL2
            oneEdgeSel_r  <= sfrWrData[ext_irq_pkg::ONE_EDGE_BIT];  // RL2
        end
    end

    // Field extraction from the configuration register
    assign zeroSel = extCfg_r[ext_irq_pkg::ZERO_SEL_LSB +: ext_irq_pkg::SEL_WIDTH];
    assign oneSel  = extCfg_r[ext_irq_pkg::ONE_SEL_LSB +: ext_irq_pkg::SEL_WIDTH];
    assign zeroPol = extCfg_r[ext_irq_pkg::ZERO_POL_BIT]; // RL2
    assign onePol  = extCfg_r[ext_irq_pkg::ONE_POL_BIT];  // RL2

    // Pin routing by select field, independent of the crossbar; read only
    assign zeroPin = portPins[zeroSel]; // RL3 RL4
    assign onePin  = portPins[oneSel];  // RL3 RL4

    // Channel for external input zero
    ext_irq_channel u_zero (
        .sys_clk   (sys_clk),
        .sys_rst   (sys_rst),
        .pinIn     (zeroPin),
        .polarity  (zeroPol),
        .edgeSel   (zeroEdgeSel_r),
        .vectorAck (irqZeroAck),
        .swWrite   (tconWrite),
        .swValue   (sfrWrData[ext_irq_pkg::ZERO_PEND_BIT]),
        .pending   (irqZeroPending)
    );

    // Channel for external input one
    ext_irq_channel u_one (
        .sys_clk   (sys_clk),
        .sys_rst   (sys_rst),
        .pinIn     (onePin),
        .polarity  (onePol),
        .edgeSel   (oneEdgeSel_r),
        .vectorAck (irqOneAck),
        .swWrite   (tconWrite),
        .swValue   (sfrWrData[ext_irq_pkg::ONE_PEND_BIT]),
        .pending   (irqOnePending)
    );

    // Read multiplexer; unmapped addresses and foreign timer bits read zero
    always_comb begin
        rdData_nxt = 8'h00;
        unique case (sfrAddr)
            ext_irq_pkg::TIMER_CTRL_ADDR: begin
                rdData_nxt[ext_irq_pkg::ZERO_EDGE_BIT] = zeroEdgeSel_r;
                rdData_nxt[ext_irq_pkg::ZERO_PEND_BIT] = irqZeroPending; // RL6
                rdData_nxt[ext_irq_pkg::ONE_EDGE_BIT]  = oneEdgeSel_r;
                rdData_nxt[ext_irq_pkg::ONE_PEND_BIT]  = irqOnePending;  // RL6
            end
            ext_irq_pkg::EXT_CFG_ADDR: begin
                rdData_nxt = extCfg_r;
            end
            ext_irq_pkg::EXT_PRIO_ADDR: begin
                rdData_nxt = extPrio_r;
            end
            default: begin
                rdData_nxt = 8'h00;
            end
        endcase
    end

    // Registered read data, loaded on each read strobe
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rdData_r <= 8'h00;
        end else if (sfrRdEn) begin
            rdData_r <= rdData_nxt;
        end
    end

    assign sfrRdData                = rdData_r;
    assign extPriority              = extPrio_r;
    assign counterArrayHighPriority = extPrio_r[ext_irq_pkg::COUNTER_PRIO_BIT]; // RL11

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    property p_cfg_write;
        (sfrWrEn && sfrAddr == ext_irq_pkg::EXT_CFG_ADDR)
            |=> (extCfg_r == $past(sfrWrData));
    endproperty
    a_cfg_write: assert property (p_cfg_write) else $error("config write lost"); // RL2

    property p_edge_sel_write;
        tconWrite |=> (zeroEdgeSel_r == $past(sfrWrData[0]))
                      && (oneEdgeSel_r == $past(sfrWrData[2]));
    endproperty
    a_edge_sel_write: assert property (p_edge_sel_write) else $error("mode write lost"); // RL2

    property p_prio_bit;
        (sfrWrEn && sfrAddr == ext_irq_pkg::EXT_PRIO_ADDR)
            |=> (counterArrayHighPriority == $past(sfrWrData[2]));
    endproperty
    a_prio_bit: assert property (p_prio_bit) else $error("priority bit wrong"); // RL11

    property p_pend_read;
        (sfrRdEn && sfrAddr == ext_irq_pkg::TIMER_CTRL_ADDR)
            |=> (sfrRdData[1] == $past(irqZeroPending))
                && (sfrRdData[3] == $past(irqOnePending));
    endproperty
    a_pend_read: assert property (p_pend_read) else $error("pending readback"); // RL6

    property p_route_zero;
        (!zeroEdgeSel_r && zeroPol && $stable(zeroSel) [*4])
            |-> (irqZeroPending == $past(portPins[zeroSel], 3));
    endproperty
    a_route_zero: assert property (p_route_zero) else $error("pin route zero"); // RL3

    property p_route_one;
        (!oneEdgeSel_r && !onePol && $stable(oneSel)) [*4]
            |-> (irqOnePending == !$past(portPins[oneSel], 3));
    endproperty
    a_route_one: assert property (p_route_one) else $error("pin route one"); // RL3

    // Level input still active at the vector keeps the request raised
    property p_level_rerequest;
        (!zeroEdgeSel_r && (zeroPin == zeroPol) && $stable(zeroPol)) [*3]
            ##1 (!zeroEdgeSel_r && (zeroPin == zeroPol) && $stable(zeroPol) && irqZeroAck)
            |=> irqZeroPending;
    endproperty
    a_level_rerequest: assert property (p_level_rerequest) else $error("no re-request"); // RL10

    // Register contents only change on their own write strobe
    property p_cfg_hold;
        !(sfrWrEn && sfrAddr == ext_irq_pkg::EXT_CFG_ADDR) |=> $stable(extCfg_r);
    endproperty
    a_cfg_hold: assert property (p_cfg_hold) else $error("config drifted"); // RL2

    property p_edge_sel_hold;
        !tconWrite |=> ($stable(zeroEdgeSel_r) && $stable(oneEdgeSel_r));
    endproperty
    a_edge_sel_hold: assert property (p_edge_sel_hold) else $error("mode drifted"); // RL2

    property p_prio_hold;
        !(sfrWrEn && sfrAddr == ext_irq_pkg::EXT_PRIO_ADDR) |=> $stable(extPriority);
    endproperty
    a_prio_hold: assert property (p_prio_hold) else $error("priority drifted"); // RL11

    // Read data stands until the next read strobe
    property p_rd_hold;
        !sfrRdEn |=> $stable(sfrRdData);
    endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read data drifted"); // RL6

    property p_timer_control_reg_upper_zero;
        (sfrRdEn && sfrAddr == ext_irq_pkg::TIMER_CTRL_ADDR) |=> (sfrRdData[7:4] == 4'h0);
    endproperty
    a_timer_control_reg_upper_zero: assert property (p_timer_control_reg_upper_zero) else $error("timer_control_reg upper bits"); // RL6

endmodule : external_interrupt_inputs

// File: tb/ext_irq_source.sv
// Behavioural external interrupt source driving one open-drain port pin
`timescale 1ns/1ps
module ext_irq_source (
    // Request from the bench
    input  wire logic request,
    input  wire logic activeHigh,
    // Port pin with pull-up
    output logic      pin
);
    // Open-drain with latch at one: only pulls low, released pin floats high
    assign pin = (request != activeHigh) ? 1'b0 : 1'b1;
endmodule : ext_irq_source

// File: tb/tb_external_interrupt_inputs.sv
// Self-checking bench for the external interrupt inputs
`timescale 1ns/1ps
module tb_external_interrupt_inputs;
    logic       sys_clk;
    logic       sys_rst;
    logic [7:0] otherPins;
    logic [7:0] portPins;
    logic [7:0] sfrAddr;
    logic       sfrWrEn;
    logic [7:0] sfrWrData;
    logic       sfrRdEn;
    logic [7:0] sfrRdData;
    logic       irqZeroAck;
    logic       irqOneAck;
    logic       irqZeroPending;
    logic       irqOnePending;
    logic       counterArrayHighPriority;
    logic [7:0] extPriority;
    logic       reqZero;
    logic       reqOne;
    logic       zeroHigh;
    logic       oneHigh;
    logic       pinZero;
    logic       pinOne;
    int         errTotal;
    int         nTests;
    int         cycles;

    // Sources sit on pins 2 and 5, the rest come from the bench
    assign portPins = {otherPins[7:6], pinOne, otherPins[4:3], pinZero, otherPins[1:0]};

    external_interrupt_inputs #(.PIN_COUNT(8)) external_interrupt_inputs_i (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .portPins(portPins), .sfrAddr(sfrAddr),
        .sfrWrEn(sfrWrEn), .sfrWrData(sfrWrData), .sfrRdEn(sfrRdEn), .sfrRdData(sfrRdData),
        .irqZeroAck(irqZeroAck), .irqOneAck(irqOneAck), .irqZeroPending(irqZeroPending),
        .irqOnePending(irqOnePending), .counterArrayHighPriority(counterArrayHighPriority),
        .extPriority(extPriority));
    ext_irq_source srcZero (.request(reqZero), .activeHigh(zeroHigh), .pin(pinZero));
    ext_irq_source srcOne (.request(reqOne), .activeHigh(oneHigh), .pin(pinOne));

    // Clock generation
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    // Hang guard
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            errTotal = errTotal + 1;
            giveVerdict();
        end
    end

    task automatic cyc(input int n);
        repeat (n) @(negedge sys_clk);
    endtask : cyc

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        nTests = nTests + 1;
        if (seen !== exp) begin
            errTotal = errTotal + 1;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        sfrAddr = a;
        sfrWrData = d;
        sfrWrEn = 1'b1;
        cyc(1);
        sfrWrEn = 1'b0;
        cyc(1);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
        sfrAddr = a;
        sfrRdEn = 1'b1;
        cyc(1);
        sfrRdEn = 1'b0;
        check(what, sfrRdData, exp);
        cyc(1);
    endtask : rd

    task automatic test_reset_values;
        rd(ext_irq_pkg::TIMER_CTRL_ADDR, ext_irq_pkg::TIMER_CTRL_RST, "timer_control_reg");
        rd(ext_irq_pkg::EXT_CFG_ADDR, ext_irq_pkg::EXT_CFG_RST, "cfg");
        rd(ext_irq_pkg::EXT_PRIO_ADDR, ext_irq_pkg::EXT_PRIO_RST, "prio");
        rd(8'h90, 8'h00, "unmapped");
        $display("test reset values done");
    endtask : test_reset_values

    task automatic test_priority;
        wr(ext_irq_pkg::EXT_PRIO_ADDR, 8'h04);
        check("prio bit", {7'h00, counterArrayHighPriority}, 8'h01);
        check("prio reg", extPriority, 8'h04);
        wr(ext_irq_pkg::EXT_PRIO_ADDR, 8'hfb);
        check("prio low", {7'h00, counterArrayHighPriority}, 8'h00);
        rd(ext_irq_pkg::EXT_PRIO_ADDR, 8'hfb, "prio read");
        $display("test priority done");
    endtask : test_priority

    task automatic test_level;
        wr(ext_irq_pkg::EXT_CFG_ADDR, 8'h5a);
        cyc(4);
        check("unselected pin", {6'h00, irqOnePending, irqZeroPending}, 8'h00);
        reqZero = 1'b1;
        cyc(4);
        check("level zero", {7'h00, irqZeroPending}, 8'h01);
        irqZeroAck = 1'b1;
        cyc(1);
        irqZeroAck = 1'b0;
        cyc(1);
        check("level after ack", {7'h00, irqZeroPending}, 8'h01);
        rd(ext_irq_pkg::TIMER_CTRL_ADDR, 8'h02, "timer_control_reg zero");
        reqZero = 1'b0;
        reqOne = 1'b1;
        cyc(4);
        check("level zero off", {7'h00, irqZeroPending}, 8'h00);
        check("level one", {7'h00, irqOnePending}, 8'h01);
        rd(ext_irq_pkg::TIMER_CTRL_ADDR, 8'h08, "timer_control_reg one");
        reqOne = 1'b0;
        cyc(4);
        check("level one off", {7'h00, irqOnePending}, 8'h00);
        $display("test level done");
    endtask : test_level

    task automatic test_edge;
        wr(ext_irq_pkg::TIMER_CTRL_ADDR, 8'h05);
        reqZero = 1'b1;
        cyc(5);
        check("edge zero", {7'h00, irqZeroPending}, 8'h01);
        reqZero = 1'b0;
        cyc(4);
        rd(ext_irq_pkg::TIMER_CTRL_ADDR, 8'h07, "edge latched");
        irqZeroAck = 1'b1;
        cyc(1);
        irqZeroAck = 1'b0;
        check("edge ack", {7'h00, irqZeroPending}, 8'h00);
        reqZero = 1'b1;
        cyc(2);
        irqZeroAck = 1'b1;
        cyc(1);
        irqZeroAck = 1'b0;
        check("edge beats ack", {7'h00, irqZeroPending}, 8'h01);
        cyc(1);
        irqZeroAck = 1'b1;
        cyc(1);
        irqZeroAck = 1'b0;
        check("edge second ack", {7'h00, irqZeroPending}, 8'h00);
        reqZero = 1'b0;
        reqOne = 1'b1;
        cyc(5);
        check("edge one", {7'h00, irqOnePending}, 8'h01);
        cyc(3);
        check("edge one hold", {7'h00, irqOnePending}, 8'h01);
        wr(ext_irq_pkg::TIMER_CTRL_ADDR, 8'h05);
        rd(ext_irq_pkg::TIMER_CTRL_ADDR, 8'h05, "sw clear");
        reqOne = 1'b0;
        cyc(4);
        reqOne = 1'b1;
        cyc(5);
        check("edge one again", {7'h00, irqOnePending}, 8'h01);
        irqOneAck = 1'b1;
        cyc(1);
        irqOneAck = 1'b0;
        check("edge one ack", {7'h00, irqOnePending}, 8'h00);
        reqOne = 1'b0;
        $display("test edge done");
    endtask : test_edge

    task automatic giveVerdict;
        $display("comparisons %0d mismatches %0d", nTests, errTotal);
        if (errTotal == 0 && nTests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : giveVerdict

    // Main sequence
    initial begin
        errTotal = 0;
        nTests = 0;
        cycles = 0;
        sys_rst = 1'b1;
        otherPins = 8'hff;
        sfrAddr = 8'h00;
        sfrWrEn = 1'b0;
        sfrWrData = 8'h00;
        sfrRdEn = 1'b0;
        irqZeroAck = 1'b0;
        irqOneAck = 1'b0;
        reqZero = 1'b0;
        reqOne = 1'b0;
        zeroHigh = 1'b1;
        oneHigh = 1'b0;
        cyc(4);
        sys_rst = 1'b0;
        test_reset_values();
        test_priority();
        test_level();
        test_edge();
        giveVerdict();
    end
endmodule : tb_external_interrupt_inputs
